//--- hw/vrc_pkg.sv
// Package for the reference control block: register offset, field positions, reset value.
// Assumes an 8-bit special function register bus with an 8-bit address.
package vrc_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] VRC_REF_CTRL_ADDR = 8'hd1;
   localparam logic [7:0] VRC_REF_CTRL_RST  = 8'h00;
   localparam logic [7:0] VRC_REF_CTRL_MASK = 8'h1f;
   // ==========================================================
   // Field positions
   localparam int VRC_BIT_CONV_A_SEL = 4;
   localparam int VRC_BIT_CONV_B_SEL = 3;
   localparam int VRC_BIT_TEMP_ON    = 2;
   localparam int VRC_BIT_BIAS_ON    = 1;
   localparam int VRC_BIT_BUF_ON     = 0;
   // Highest input index of the first converter's multiplexer
   localparam logic [3:0] VRC_CONV_A_TEMP_CH = 4'h8;

   // Static analog control levels
   typedef struct packed {
      logic conv_a_ref_select;
      logic conv_b_ref_select;
      logic temp_sensor_on;
      logic bias_generator_on;
      logic ref_buffer_on;
   } vrc_ctrl_t;

   // Field layout of the stored byte
   function automatic vrc_ctrl_t vrc_unpack(input logic [7:0] v);
      vrc_unpack = vrc_ctrl_t'(v[4:0]);
   endfunction
endpackage

//--- hw/vrc_reg.sv
// Storage flop for the reference control byte.
// Assumes write strobe and data are synchronous to mclk_i.
`timescale 1ns/1ps
module vrc_reg
(
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] q_o
);
   import vrc_pkg::*;
   // ==========================================================
   // Storage
   // Unused high bits are dropped at the write
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         q_o <= VRC_REF_CTRL_RST;
      end
      else if (we_i)
      begin
         q_o <= wdata_i & VRC_REF_CTRL_MASK;
      end
   end
endmodule

//--- hw/vrc_top.sv
// Reference control register block with its static analog control outputs.
// Assumes a synchronous SFR bus on mclk_i: one-cycle write strobe, read data taken next cycle.
`timescale 1ns/1ps
module vrc_top
(
   input  wire logic             mclk_i,
   input  wire logic             reset_n_i,
   input  wire logic [7:0]       sfr_addr_i,
   input  wire logic             sfr_wr_i,
   input  wire logic             sfr_rd_i,
   input  wire logic [7:0]       sfr_wdata_i,
   output logic      [7:0]       sfr_rdata_o,
   output vrc_pkg::vrc_ctrl_t    ctrl_o,
   output logic                  temp_out_en_o,
   output logic                  ref_pin_out_en_o,
   output logic      [3:0]       temp_sensor_ch_o
);
   import vrc_pkg::*;

   // ==========================================================
   // Helper functions
   // Address match for the single register of this block
   function automatic logic vrc_hit(input logic [7:0] addr);
      vrc_hit = (addr == VRC_REF_CTRL_ADDR);
   endfunction

   // Clears the unused high bits; read path and checks share it
   function automatic logic [7:0] vrc_clean(input logic [7:0] v);
      vrc_clean = v & VRC_REF_CTRL_MASK;
   endfunction

   // ==========================================================
   // Internal nets
   logic       hit;    // Register addressed this cycle
   logic       we;     // Write taken at this edge
   logic       re;     // Read taken at this edge
   logic [7:0] reg_q;  // Stored control byte
   vrc_ctrl_t  ctrl_d; // Field view of the stored byte

   // ==========================================================
   // Decode
   // Strobes count only when the register address is on the bus
   assign hit    = vrc_hit(sfr_addr_i);
   assign we     = hit & sfr_wr_i;
   assign re     = hit & sfr_rd_i;
   assign ctrl_d = vrc_unpack(reg_q);

   // ==========================================================
   // Storage
   // Write data lands at the edge that takes the write
   vrc_reg vrc_reg_inst
   (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .we_i      (we),
      .wdata_i   (sfr_wdata_i),
      .q_o       (reg_q)
   );

   // ==========================================================
   // Read port
   // Registered; zero when not addressed so a shared read mux can OR it in
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sfr_rdata_o <= 8'h00;
      end
      else
      begin
         sfr_rdata_o <= re ? vrc_clean(reg_q) : 8'h00;
      end
   end

   // ==========================================================
   // Analog control levels, one flop stage after the register
   // Reference selects and enables as static levels for the analog side
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_o <= vrc_ctrl_t'(VRC_REF_CTRL_RST[4:0]);
      end
      else
      begin
         ctrl_o <= ctrl_d;
      end
   end

   // Sensor drive enable; low leaves the sensor output floating
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         temp_out_en_o <= VRC_REF_CTRL_RST[VRC_BIT_TEMP_ON];
      end
      else
      begin
         temp_out_en_o <= ctrl_d.temp_sensor_on;
      end
   end

   // Reference pin buffer drive enable; low leaves the pin floating
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ref_pin_out_en_o <= VRC_REF_CTRL_RST[VRC_BIT_BUF_ON];
      end
      else
      begin
         ref_pin_out_en_o <= ctrl_d.ref_buffer_on;
      end
   end

   // Sensor channel index: fixed wiring into the first converter multiplexer
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         temp_sensor_ch_o <= VRC_CONV_A_TEMP_CH;
      end
      else
      begin
         temp_sensor_ch_o <= VRC_CONV_A_TEMP_CH;
      end
   end

   // ==========================================================
   // Checks: reset, storage and read port
   // Reset leaves register, read data, control fields and drive enables cleared; the sensor channel holds VRC_CONV_A_TEMP_CH
   a_reset_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> (reg_q == VRC_REF_CTRL_RST) && (sfr_rdata_o == 8'h00) &&
         (ctrl_o == vrc_unpack(VRC_REF_CTRL_RST)) && !temp_out_en_o && !ref_pin_out_en_o)
      else $error("reset state wrong");

   // Unused bits read zero
   a_high_bits_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      sfr_rdata_o[7:5] == 3'b000) else $error("high bits not zero");

   // Unused bits never stored
   a_high_bits_store: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      reg_q[7:5] == 3'b000) else $error("high bits stored");

   // A taken write lands in the register at once
   a_write_lands: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> reg_q == vrc_clean($past(sfr_wdata_i))) else $error("write did not land");

   // Writes to other addresses leave the register alone
   a_other_addr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (sfr_wr_i && !hit) |=> $stable(reg_q)) else $error("foreign write changed register");

   // Read returns the stored value one cycle later
   a_read_back: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (re && !$past(we)) |=> sfr_rdata_o == {3'b000, $past(reg_q[4:0])})
      else $error("read data wrong");

   // Read data idles at zero
   a_read_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !re |=> sfr_rdata_o == 8'h00) else $error("read data not idle");

   // ==========================================================
   // Checks: analog levels two cycles after a write, the fixed sensor channel, levels holding without a write
   // First converter reference select
   a_write_sel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ctrl_o.conv_a_ref_select == $past(sfr_wdata_i[VRC_BIT_CONV_A_SEL], 2))
      else $error("select a mismatch");

   // Second converter reference select
   a_write_sel_b: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ctrl_o.conv_b_ref_select == $past(sfr_wdata_i[VRC_BIT_CONV_B_SEL], 2))
      else $error("select b mismatch");

   // Sensor enable field
   a_write_temp: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ctrl_o.temp_sensor_on == $past(sfr_wdata_i[VRC_BIT_TEMP_ON], 2))
      else $error("sensor field mismatch");

   // Bias enable field
   a_write_bias: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ctrl_o.bias_generator_on == $past(sfr_wdata_i[VRC_BIT_BIAS_ON], 2))
      else $error("bias field mismatch");

   // Buffer enable field
   a_write_buf: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ctrl_o.ref_buffer_on == $past(sfr_wdata_i[VRC_BIT_BUF_ON], 2))
      else $error("buffer field mismatch");

   // Sensor drive enable follows the written bit
   a_temp_float: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 temp_out_en_o == $past(sfr_wdata_i[VRC_BIT_TEMP_ON], 2))
      else $error("sensor enable mismatch");

   // Pin buffer drive enable follows the written bit
   a_buf_float: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      we |=> ##1 ref_pin_out_en_o == $past(sfr_wdata_i[VRC_BIT_BUF_ON], 2))
      else $error("buffer enable mismatch");

   // Sensor channel never moves
   a_temp_chan: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      temp_sensor_ch_o == VRC_CONV_A_TEMP_CH) else $error("sensor channel wrong");

   // No level changes without a write two cycles back
   a_hold_value: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !we [*2] |=> $stable(ctrl_o)) else $error("control changed without write");

   // ==========================================================
   // Cover points for the main scenarios
   c_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      we);
   c_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      re);
   c_write_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      we && re);
   c_dac_ref: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      ctrl_o.conv_a_ref_select && ctrl_o.bias_generator_on && ctrl_o.ref_buffer_on);
   c_all_on: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      ctrl_o == 5'h1f);
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the reference control register block.
// Assumes vrc_pkg and vrc_top are compiled first; the bench drives the SFR bus itself.
`timescale 1ns/1ps
module tb_top;
   import vrc_pkg::*;
   // ==========================================================
   // Signals and shadow state
   logic             mclk_i = 1'b0;
   logic             reset_n_i = 1'b0;
   logic [7:0]       sfr_addr_i = 8'h00;
   logic             sfr_wr_i = 1'b0;
   logic             sfr_rd_i = 1'b0;
   logic [7:0]       sfr_wdata_i = 8'h00;
   logic [7:0]       sfr_rdata_o;
   vrc_ctrl_t        ctrl_o;
   logic             temp_out_en_o;
   logic             ref_pin_out_en_o;
   logic [3:0]       temp_sensor_ch_o;
   logic [10:0]      ctrl_seen;
   logic [7:0]       exp_q[$];
   logic [7:0]       reg_m = 8'h00;
   logic [7:0]       m1 = 8'h00;
   logic [7:0]       m2 = 8'h00;
   logic             pend = 1'b0;
   int               miscompares = 0;
   int               total_checks = 0;

   vrc_top vrc_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o), .ctrl_o(ctrl_o), .temp_out_en_o(temp_out_en_o),
      .ref_pin_out_en_o(ref_pin_out_en_o), .temp_sensor_ch_o(temp_sensor_ch_o));

   // Every level output in one word for the compare
   assign ctrl_seen = {ctrl_o, temp_out_en_o, ref_pin_out_en_o, temp_sensor_ch_o};

   // Free-running 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   // ==========================================================
   // Compare and bus tasks
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error read at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_ctrl(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error ctrl at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Software side: a converter fed from the first DAC needs bias and buffer on
   function automatic logic [7:0] sw_rules(input logic [7:0] d);
      sw_rules = d[VRC_BIT_CONV_A_SEL] ?
                 (d | (8'h01 << VRC_BIT_BIAS_ON) | (8'h01 << VRC_BIT_BUF_ON)) : d;
   endfunction

   // Expected levels: five fields, the two drive enables, the fixed sensor channel
   function automatic logic [10:0] ctrl_exp(input logic [7:0] m);
      ctrl_exp = {m[4:0], m[VRC_BIT_TEMP_ON], m[VRC_BIT_BUF_ON], VRC_CONV_A_TEMP_CH};
   endfunction

   // One bus cycle; the read expectation is noted before any write lands
   task automatic cyc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      sfr_wr_i <= wr;
      sfr_rd_i <= rd;
      sfr_addr_i <= a;
      sfr_wdata_i <= sw_rules(d);
      if (rd) exp_q.push_back((a == VRC_REF_CTRL_ADDR) ? reg_m : 8'h00);
      if (wr && a == VRC_REF_CTRL_ADDR) reg_m = sw_rules(d) & VRC_REF_CTRL_MASK;
   endtask

   task automatic final_report();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Monitor: read data one cycle after the read, outputs two after a write
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pend <= 1'b0;
         m1 <= 8'h00;
         m2 <= 8'h00;
      end
      else
      begin
         if (pend) chk_rd(sfr_rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
         chk_ctrl(ctrl_seen, ctrl_exp(m2));
         pend <= sfr_rd_i;
         if (sfr_wr_i && sfr_addr_i == VRC_REF_CTRL_ADDR) m1 <= sfr_wdata_i & VRC_REF_CTRL_MASK;
         m2 <= m1;
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h99ca));
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      cyc(1'b0, 1'b1, 8'hd1, 8'h00);
      cyc(1'b1, 1'b1, 8'hd1, 8'hff);
      for (int i = 0; i < 6; i++) cyc(1'b1, 1'b1, 8'hd1, 8'h01 << i);
      cyc(1'b1, 1'b1, 8'hd0, 8'h1f);
      cyc(1'b1, 1'b1, 8'hd1, 8'h00);
      cyc(1'b0, 1'b1, 8'hd1, 8'h00);
      repeat (300) cyc(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)),
                       $urandom_range(0, 1) ? 8'hd1 : 8'($urandom), 8'($urandom));
      cyc(1'b1, 1'b0, 8'hd1, 8'h1f);
      repeat (3) cyc(1'b0, 1'b0, 8'h00, 8'h00);
      reset_n_i <= 1'b0;
      reg_m = 8'h00;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      cyc(1'b0, 1'b1, 8'hd1, 8'h00);
      repeat (4) cyc(1'b0, 1'b0, 8'h00, 8'h00);
      if (exp_q.size() != 0) miscompares++;
      final_report();
   end
endmodule
